// ---- bench/crs_host_model.sv ----
`timescale 1ns/1ps
// Host side of the link: sclk idles high and runs only inside frames
module crs_host_model (
	output logic      sclk,
	output logic      csn,
	output logic      din,
	input  wire logic dout,
	input  wire logic tieCs
);
	// Released lines rest at their pull-up level
	initial begin
		sclk = 1'h1;
		csn  = 1'h1;
		din  = 1'h1;
	end
	// One bit: din moves after the fall, dout is taken at the rise
	task automatic bitx(input logic b, output logic s);
		sclk = 1'h0;
		din  = b;
		#100;
		sclk = 1'h1;
		s    = dout;
		#100;
	endtask : bitx
	// First n bits of a command-plus-word, with a pause after the command byte
	task automatic frame(input logic [31:0] w, input int n, input int gap,
		output logic [23:0] rd);
		logic s;
		rd  = 24'h0;
		csn = 1'h0;
		#100;
		for (int i = 31; i > 31 - n; i--) begin
			if (i == 23) #(gap);
			bitx(w[i], s);
			if (i < 24) rd[i] = s;
		end
		csn = ~tieCs;
		din = 1'h1;
		#300;
	endtask : frame
endmodule : crs_host_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import crs_pkg::*;
	logic         clock, rstn, sclkPin, csnPin, dinPin, doutPin, doutOe, rdyPinN;
	logic [4:0]   ev;
	logic [23:0]  mainResult, regRdData, rd;
	logic [15:0]  auxResult;
	logic         mainEnable, auxEnable, regWrValid, regWrReady, wrOverflow;
	logic         mainRdyBit, auxRdyBit, tieCs;
	logic [3:0]   rdSel;
	crsCtlWord_t  regWrWord;
	int           n_errors, total_checks, nOvf, k;

	// Clock at 40 MHz
	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end

	crs_host_model host (.sclk(sclkPin), .csn(csnPin), .din(dinPin), .dout(doutPin),
		.tieCs(tieCs));

	crs_ready_serial uut (.clock(clock), .rstn(rstn), .sclkPin(sclkPin), .csnPin(csnPin),
		.dinPin(dinPin), .doutPin(doutPin), .doutOe(doutOe), .rdyPinN(rdyPinN),
		.mainResultWr(ev[0]), .mainResult(mainResult), .auxResultWr(ev[1]),
		.auxResult(auxResult), .mainUpdateSoon(ev[2]), .auxUpdateSoon(ev[3]),
		.mainEnable(mainEnable), .auxEnable(auxEnable), .calDone(ev[4]), .rdSel(rdSel),
		.regRdData(regRdData), .regWrValid(regWrValid), .regWrWord(regWrWord),
		.regWrReady(regWrReady), .wrOverflow(wrOverflow), .mainRdyBit(mainRdyBit),
		.auxRdyBit(auxRdyBit));

	// Dropped-word pulses are counted, one per overflow
	always @(posedge clock) if (wrOverflow === 1'h1) nOvf++;

	task chk(input string what, input logic [27:0] exp, input logic [27:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_sim
	task cyc(input int n);
		repeat (n) @(posedge clock);
	endtask : cyc
	// One-cycle event pulse, then time for the ready pin to settle
	task fire(input logic [4:0] e);
		@(posedge clock);
		ev <= e;
		@(posedge clock);
		ev <= 5'h0;
		cyc(3);
		#1;
	endtask : fire
	// Link traffic starts off the clock edge: the two are unrelated
	task xfer(input logic [31:0] w, input int n, input int gap);
		@(posedge clock);
		#7;
		host.frame(w, n, gap, rd);
	endtask : xfer

	task t_reset;
		chk("rdyPinN", 1'h1, rdyPinN);
		chk("regWrValid", 1'h0, regWrValid);
		chk("doutOe", 1'h0, doutOe);
		chk("rdyBits", 2'h0, {auxRdyBit, mainRdyBit});
	endtask : t_reset
	task t_main;
		mainResult <= 24'h9a5c31;
		fire(5'h01);
		chk("rdyPinN", 1'h0, rdyPinN);
		chk("mainRdyBit", 1'h1, mainRdyBit);
		xfer({8'h44, 24'h0}, 32, 1000);
		chk("main data", 24'h9a5c31, rd);
		chk("rdyPinN", 1'h1, rdyPinN);
		chk("mainRdyBit", 1'h0, mainRdyBit);
		xfer({8'h43, 24'h0}, 32, 0);
		chk("other data", 24'h3c5a96, rd);
		chk("rdSel", 4'h3, rdSel);
	endtask : t_main
	// Chip select held low from the first frame of the scenario onward
	task t_aux3w;
		tieCs = 1'h1;
		auxResult <= 16'hc0de;
		fire(5'h02);
		chk("auxRdyBit", 1'h1, auxRdyBit);
		xfer({8'h40, 24'h0}, 32, 0);
		chk("status", 2'h2, rd[1:0]);
		xfer({8'h45, 24'h0}, 32, 0);
		chk("aux data", {8'h00, 16'hc0de}, rd);
		chk("rdyPinN", 1'h1, rdyPinN);
		chk("doutOe", 1'h1, doutOe);
		tieCs = 1'h0;
	endtask : t_aux3w
	task t_soon;
		fire(5'h01);
		fire(5'h04);
		chk("rdyPinN", 1'h1, rdyPinN);
		fire(5'h02);
		chk("rdyPinN", 1'h0, rdyPinN);
		fire(5'h08);
		chk("rdyPinN", 1'h1, rdyPinN);
	endtask : t_soon
	task t_disable;
		auxEnable <= 1'h0;
		fire(5'h02);
		chk("rdyPinN", 1'h1, rdyPinN);
		fire(5'h01);
		chk("rdyPinN", 1'h0, rdyPinN);
		xfer({8'h44, 24'h0}, 32, 0);
		chk("rdyPinN", 1'h1, rdyPinN);
		xfer({8'h45, 24'h0}, 32, 0);
		auxEnable <= 1'h1;
		cyc(4);
		#1;
		chk("rdyPinN", 1'h1, rdyPinN);
		// Same again with the main converter switched off
		@(posedge clock);
		mainEnable <= 1'h0;
		fire(5'h01);
		chk("rdyPinN", 1'h1, rdyPinN);
		xfer({8'h44, 24'h0}, 32, 0);
		@(posedge clock);
		mainEnable <= 1'h1;
		cyc(4);
		#1;
		chk("rdyPinN", 1'h1, rdyPinN);
	endtask : t_disable
	task t_cal;
		fire(5'h10);
		chk("rdyPinN", 1'h0, rdyPinN);
		cyc(40);
		#1;
		chk("rdyPinN", 1'h0, rdyPinN);
		xfer({8'h01, 24'h000010}, 32, 0);
		chk("rdyPinN", 1'h1, rdyPinN);
	endtask : t_cal
	// A cut-short frame, then the FIFO filled past full with the far side stalled
	task t_fifo;
		regWrReady <= 1'h0;
		xfer({8'h44, 24'h0}, 5, 0);
		for (int i = 0; i < 18; i++) xfer({8'h03, 24'h100000 + i[23:0]}, 32, 0);
		chk("overflows", 28'h1, 28'(nOvf));
		for (int i = 0; i < 17; i++) begin
			k = 0;
			while (regWrValid !== 1'h1 && k < 50) begin
				@(posedge clock);
				#1;
				k++;
			end
			if (k == 50) begin
				n_errors++;
				end_sim;
			end
			chk("regWrWord", {4'h3, 24'h100000 + i[23:0]}, regWrWord);
			@(posedge clock);
			regWrReady <= 1'h1;
			@(posedge clock);
			regWrReady <= 1'h0;
			#1;
		end
		cyc(3);
		#1;
		chk("regWrValid", 1'h0, regWrValid);
		regWrReady <= 1'h1;
	endtask : t_fifo

	// Reset in mid-run with both results pending must drop everything
	task t_rst;
		fire(5'h03);
		chk("rdyPinN", 1'h0, rdyPinN);
		@(posedge clock);
		rstn <= 1'h0;
		cyc(2);
		#1;
		chk("rdyPinN", 1'h1, rdyPinN);
		chk("rdyBits", 2'h0, {auxRdyBit, mainRdyBit});
		@(posedge clock);
		rstn <= 1'h1;
		cyc(4);
		#1;
		chk("rdyPinN", 1'h1, rdyPinN);
	endtask : t_rst

	// Hang guard: far beyond the longest expected run
	initial begin
		#1000000;
		n_errors++;
		end_sim;
	end

	// Main sequence
	initial begin
		rstn = 1'h0;
		ev = 5'h0;
		mainResult = 24'h0;
		auxResult = 16'h0;
		mainEnable = 1'h1;
		auxEnable = 1'h1;
		regRdData = 24'h3c5a96;
		regWrReady = 1'h1;
		tieCs = 1'h0;
		n_errors = 0;
		total_checks = 0;
		nOvf = 0;
		cyc(16);
		rstn <= 1'h1;
		cyc(4);
		t_reset;
		t_main;
		t_aux3w;
		t_soon;
		t_disable;
		t_cal;
		t_rst;
		t_fifo;
		end_sim;
	end
endmodule : tb_top

// ---- verilog/crs_fifo.sv ----
`timescale 1ns/1ps
module crs_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 16
) (
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic [WIDTH-1:0]      outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_q;
	logic [AW-1:0]    rdPtr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	// Full and empty come straight from the occupancy count
	assign inReady  = count_q != (AW+1)'(DEPTH);
	assign outValid = count_q != '0;
	assign outData  = mem[rdPtr_q];
	assign push     = inValid & inReady;
	assign pop      = outValid & outReady;

	// Storage has no reset; only the pointers and the count need a defined state
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end

	// Pointers wrap naturally because the depth is a power of two
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_q + AW'(push);
			rdPtr_q <= rdPtr_q + AW'(pop);
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	fifoCount_a: assert property (@(posedge clock) disable iff (!rstn)
		push && !pop |=> count_q == $past(count_q) + 1'b1)
		else $error("fifo count did not rise on push");
endmodule : crs_fifo

// ---- verilog/crs_pkg.sv ----
package crs_pkg;
	// Serial framing
	localparam logic [4:0] COMM_BITS     = 5'h08;
	localparam logic [4:0] DATA_BITS     = 5'h18;
	localparam int         COMM_RD_POS   = 6;
	localparam int         DATA_W        = 24;
	localparam int         AUX_W         = 16;
	localparam int         SEL_W         = 4;
	// Register select codes carried in the communications byte
	localparam logic [3:0] RS_STATUS     = 4'h0;
	localparam logic [3:0] RS_MODE       = 4'h1;
	localparam logic [3:0] RS_MAIN_DATA  = 4'h4;
	localparam logic [3:0] RS_AUX_DATA   = 4'h5;
	// Status word bit positions
	localparam int         STAT_MAIN_POS = 0;
	localparam int         STAT_AUX_POS  = 1;
	// Reset values and queue depth
	localparam logic [2:0] PIN_IDLE      = 3'h7;
	localparam logic       RDYN_RESET    = 1'h1;
	localparam int         FIFO_DEPTH    = 16;

	typedef struct packed {
		logic [SEL_W-1:0]  sel;
		logic [DATA_W-1:0] data;
	} crsCtlWord_t;

	typedef enum logic [1:0] {
		ST_COMM,
		ST_WRITE,
		ST_READ
	} crsState_t;
endpackage : crs_pkg

// ---- verilog/crs_ready_serial.sv ----
`timescale 1ns/1ps
module crs_ready_serial (
	input  wire logic                        clock,
	input  wire logic                        rstn,
	input  wire logic                        sclkPin,
	input  wire logic                        csnPin,
	input  wire logic                        dinPin,
	output logic                             doutPin,
	output logic                             doutOe,
	output logic                             rdyPinN,
	input  wire logic                        mainResultWr,
	input  wire logic [crs_pkg::DATA_W-1:0]  mainResult,
	input  wire logic                        auxResultWr,
	input  wire logic [crs_pkg::AUX_W-1:0]   auxResult,
	input  wire logic                        mainUpdateSoon,
	input  wire logic                        auxUpdateSoon,
	input  wire logic                        mainEnable,
	input  wire logic                        auxEnable,
	input  wire logic                        calDone,
	output logic [crs_pkg::SEL_W-1:0]        rdSel,
	input  wire logic [crs_pkg::DATA_W-1:0]  regRdData,
	output logic                             regWrValid,
	output crs_pkg::crsCtlWord_t             regWrWord,
	input  wire logic                        regWrReady,
	output logic                             wrOverflow,
	output logic                             mainRdyBit,
	output logic                             auxRdyBit
);
	import crs_pkg::*;

	logic [2:0]        syncA_q;
	logic [2:0]        syncB_q;
	logic              sclkPrev_q;
	crsState_t         state_q;
	logic [4:0]        bitCnt_q;
	logic [DATA_W-1:0] shiftIn_q;
	logic [7:0]        comm_q;
	logic              loadPend_q;
	logic [DATA_W-1:0] shiftOut_q;
	logic              mainRdy_q;
	logic              auxRdy_q;
	logic              calHold_q;
	logic [DATA_W-1:0] mainData_q;
	logic [AUX_W-1:0]  auxData_q;
	crsCtlWord_t       regWrWord_q;
	logic              regWrValid_q;

	logic              sclkS;
	logic              csnS;
	logic              dinS;
	logic              sclkRise;
	logic              sclkFall;
	logic [4:0]        lastCnt;
	logic              frameEnd;
	logic              commDone;
	logic              wrDone;
	logic              rdDone;
	logic [7:0]        commNext;
	logic [SEL_W-1:0]  selNow;
	logic              selMain;
	logic              selAux;
	crsCtlWord_t       pushWord;
	logic              pushReady;
	logic              fifoValid;
	logic              fifoReady;
	crsCtlWord_t       fifoWord;
	logic              modeAccept;
	logic              mainRdy_d;
	logic              auxRdy_d;
	logic              calHold_d;
	logic              mainBit;
	logic              auxBit;
	logic [DATA_W-1:0] statusWord;
	logic [DATA_W-1:0] rdWord;

	// Pin samples: only the second stage is ever looked at
	assign sclkS    = syncB_q[0];
	assign csnS     = syncB_q[1];
	assign dinS     = syncB_q[2];
	// Edges come from the sampled clock, so gaps between bursts cost nothing
	assign sclkRise = sclkS & ~sclkPrev_q;
	assign sclkFall = ~sclkS & sclkPrev_q;

	// Frame decode; a raised select aborts the frame
	assign lastCnt  = (state_q == ST_COMM) ? COMM_BITS - 5'h01 : DATA_BITS - 5'h01;
	assign frameEnd = ~csnS & sclkRise & (bitCnt_q == lastCnt);
	assign commDone = frameEnd & (state_q == ST_COMM);
	assign wrDone   = frameEnd & (state_q == ST_WRITE);
	assign rdDone   = frameEnd & (state_q == ST_READ);
	assign commNext = {shiftIn_q[6:0], dinS};
	assign selNow   = comm_q[SEL_W-1:0];
	assign selMain  = selNow == RS_MAIN_DATA;
	assign selAux   = selNow == RS_AUX_DATA;

	// Received word tagged with its destination
	assign pushWord.sel  = selNow;
	assign pushWord.data = {shiftIn_q[DATA_W-2:0], dinS};
	assign modeAccept    = wrDone & pushReady & (selNow == RS_MODE);

	// Ready bits: a new result wins over a read or pre-update clear
	assign mainRdy_d = mainResultWr | (mainRdy_q & ~(rdDone & selMain) & ~mainUpdateSoon);
	assign auxRdy_d  = auxResultWr | (auxRdy_q & ~(rdDone & selAux) & ~auxUpdateSoon);
	assign calHold_d = calDone | (calHold_q & ~modeAccept);
	// Disabled converters are masked here; the host is still expected to drain them
	assign mainBit   = (mainRdy_q & mainEnable) | calHold_q;
	assign auxBit    = (auxRdy_q & auxEnable) | calHold_q;

	// Readback source for the output shifter
	assign statusWord = {{(DATA_W-2){1'b0}}, auxBit, mainBit};
	assign rdWord = selMain ? mainData_q :
		selAux ? {{(DATA_W-AUX_W){1'b0}}, auxData_q} :
		(selNow == RS_STATUS) ? statusWord : regRdData;

	assign fifoReady  = ~regWrValid_q | regWrReady;
	assign doutPin    = shiftOut_q[DATA_W-1];
	assign rdSel      = comm_q[SEL_W-1:0];
	assign regWrValid = regWrValid_q;
	assign regWrWord  = regWrWord_q;

	// Two-flop synchronisers and edge history
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			syncA_q    <= PIN_IDLE;
			syncB_q    <= PIN_IDLE;
			sclkPrev_q <= 1'b1;
		end else begin
			syncA_q    <= {dinPin, csnPin, sclkPin};
			syncB_q    <= syncA_q;
			sclkPrev_q <= sclkS;
		end
	end

	// Frame sequencer: byte of command, then one data word
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_q  <= ST_COMM;
			bitCnt_q <= '0;
		end else if (csnS) begin
			state_q  <= ST_COMM;
			bitCnt_q <= '0;
		end else if (sclkRise) begin
			bitCnt_q <= frameEnd ? 5'h00 : bitCnt_q + 5'h01;
			case (state_q)
				ST_COMM: begin
					if (frameEnd) state_q <= commNext[COMM_RD_POS] ? ST_READ : ST_WRITE;
				end
				ST_WRITE: begin
					if (frameEnd) state_q <= ST_COMM;
				end
				ST_READ: begin
					if (frameEnd) state_q <= ST_COMM;
				end
				default: state_q <= ST_COMM;
			endcase
		end
	end

	// Input shifter and latched command byte
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			shiftIn_q  <= '0;
			comm_q     <= '0;
			loadPend_q <= 1'b0;
		end else begin
			if (sclkRise && !csnS) shiftIn_q <= {shiftIn_q[DATA_W-2:0], dinS};
			if (commDone) comm_q <= commNext;
			loadPend_q <= commDone & commNext[COMM_RD_POS];
		end
	end

	// Output shifter: loaded one cycle after the command so rdSel has settled;
	// the next falling edge is many cycles away, so nothing is missed.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			shiftOut_q <= '0;
			doutOe     <= 1'b0;
		end else begin
			doutOe <= ~csnS;
			if (loadPend_q) shiftOut_q <= rdWord;
			else if (sclkFall && state_q == ST_READ && bitCnt_q != 5'h00)
				shiftOut_q <= {shiftOut_q[DATA_W-2:0], 1'b0};
		end
	end

	// Ready state and the pin, which is a NOR of the two bits
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mainRdy_q  <= 1'b0;
			auxRdy_q   <= 1'b0;
			calHold_q  <= 1'b0;
			rdyPinN    <= RDYN_RESET;
			mainRdyBit <= 1'b0;
			auxRdyBit  <= 1'b0;
		end else begin
			mainRdy_q  <= mainRdy_d;
			auxRdy_q   <= auxRdy_d;
			calHold_q  <= calHold_d;
			rdyPinN    <= ~(mainBit | auxBit);
			mainRdyBit <= mainBit;
			auxRdyBit  <= auxBit;
		end
	end

	// Result holding registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mainData_q <= '0;
			auxData_q  <= '0;
		end else begin
			if (mainResultWr) mainData_q <= mainResult;
			if (auxResultWr) auxData_q <= auxResult;
		end
	end

	// Output stage of the write path; a full queue drops the word and flags it
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			regWrValid_q <= 1'b0;
			regWrWord_q  <= '0;
			wrOverflow   <= 1'b0;
		end else begin
			regWrValid_q <= fifoValid | (regWrValid_q & ~regWrReady);
			if (fifoValid && fifoReady) regWrWord_q <= fifoWord;
			wrOverflow <= wrDone & ~pushReady;
		end
	end

	crs_fifo #(
		.WIDTH ($bits(crsCtlWord_t)),
		.DEPTH (FIFO_DEPTH)
	) u_wrFifo (
		.clock    (clock),
		.rstn     (rstn),
		.inValid  (wrDone),
		.inReady  (pushReady),
		.inData   (pushWord),
		.outValid (fifoValid),
		.outReady (fifoReady),
		.outData  (fifoWord)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	mainSet_a: assert property (mainResultWr && mainEnable |-> ##2 !rdyPinN)
		else $error("ready pin not low after main result");
	readClr_a: assert property (rdDone && selMain && !mainResultWr |=> !mainRdy_q)
		else $error("main ready not cleared by read");
	preUpd_a: assert property (auxUpdateSoon && !auxResultWr |=> !auxRdy_q)
		else $error("aux ready not cleared before update");
	calLow_a: assert property (calDone |-> ##2 !rdyPinN)
		else $error("ready pin not low after calibration");
	norPin_a: assert property (##1 rdyPinN == !($past(mainBit) || $past(auxBit)))
		else $error("ready pin is not NOR of bits");
	disMask_a: assert property ((!mainEnable || !auxEnable) && !calHold_q &&
		!(mainRdy_q && mainEnable) && !(auxRdy_q && auxEnable) |=> rdyPinN)
		else $error("disabled converters drive ready pin");
	calKeep_a: assert property (calHold_q && !modeAccept |=> calHold_q)
		else $error("calibration ready dropped without mode write");
	outLoad_a: assert property (commDone && commNext[COMM_RD_POS] |-> ##2
		shiftOut_q == $past(rdWord))
		else $error("output shifter not loaded from selected register");
	csAbort_a: assert property (csnS |=> state_q == ST_COMM && bitCnt_q == 5'h00)
		else $error("frame not reset by chip select");

	rdFrame_c: cover property (rdDone && selMain);
	wrFrame_c: cover property (modeAccept);
	calPin_c:  cover property (calHold_q && !rdyPinN);
	fullQ_c:   cover property (wrOverflow);
endmodule : crs_ready_serial
